// [hw/sci_sync_pkg.sv]
// Package with register map, field positions, reset values and shared types of the baud and sync pin block.
package sci_sync_pkg;
   localparam logic [7:0] REG_IDX_DIV_HIGH = 8'hFC;
   localparam logic [7:0] REG_IDX_DIV_LOW = 8'hFD;
   localparam logic [7:0] REG_IDX_SYNC_IN = 8'hFE;
   localparam logic [7:0] REG_IDX_SYNC_OUT = 8'hFF;
   localparam logic [7:0] REG_IDX_CLK_CFG = 8'hFB;
   localparam logic [7:0] REG_IDX_CHAR_CFG = 8'hFA;
   localparam logic [7:0] REG_IDX_STATUS = 8'hF9;
   localparam logic [7:0] RST_SYNC_IN = 8'h03;
   localparam logic [7:0] RST_SYNC_OUT = 8'h01;
   localparam logic [7:0] RST_DIV = 8'h00;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam int BIT_SYNC_EN = 7;
   localparam int BIT_IN_INV = 6;
   localparam int BIT_RECEIVE_CLOCK_PIN_EDGE = 5;
   localparam int BIT_CARRIER_GATE = 4;
   localparam int BIT_CARRIER_LEVEL = 3;
   localparam int BIT_INPUTS_OFF = 2;
   localparam int BIT_OUT_INV = 7;
   localparam int BIT_OUT_IDLE = 6;
   localparam int BIT_TXCLK_EDGE = 5;
   localparam int BIT_TXCLK_IDLE = 4;
   localparam int BIT_REQ_FRAME = 3;
   localparam int BIT_REQ_LEVEL = 2;
   localparam int BIT_ECHO = 2;
   localparam int BIT_LOOP = 1;
   localparam int BIT_PAR_INV = 0;
   localparam int BIT_EVEN_PAR = 6;
   localparam logic [15:0] DIV_MIN = 16'h0002;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic data;
      logic clk;
      logic carrier;
   } sync_in_pins_t;

   typedef struct packed {
      logic data;
      logic clk;
      logic request;
   } sync_out_pins_t;

   typedef struct packed {
      logic bit_data;
      logic active;
      logic last;
   } tx_bit_t;
endpackage

// [hw/sci_sync_io.sv]
// Baud generator, sync pin control and AXI4-Lite register slave of the serial interface.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module sci_sync_io #(
   parameter int DIV_W = 16
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [9:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [9:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire sci_sync_pkg::sync_in_pins_t i_pins,
   output sci_sync_pkg::sync_out_pins_t o_pins,
   input wire sci_sync_pkg::tx_bit_t i_tx_bit,
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   output logic o_baud_tick,
   output logic o_rx_data,
   output logic o_rx_clk_tick,
   output logic o_tx_parity_odd
);
   import sci_sync_pkg::*;

   logic [7:0] div_hi_r, div_lo_r, sin_ctl_r, serial_data_output_ctl_r, clk_cfg_r, chr_cfg_r;
   logic aw_hold_r, w_hold_r;
   logic [9:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic w_lane_r;
   logic [DIV_W-1:0] cnt_r, cnt_nxt;
   logic div_load_r;
   logic tick;
   logic sync_en, echo, loop;
   logic [7:0] sin_eff, serial_data_output_eff;
   logic rx_clk_q_r, rx_clk_prev_r;
   logic in_data, in_clk, in_carrier;
   logic carrier_active;
   logic phase_r;
   logic req_r;
   logic [1:0] buf_cnt_r;
   tx_bit_t buf_r [2];
   logic buf_rd_r;
   tx_bit_t cur_r;
   logic cur_valid_r;
   logic wr_fire;
   logic [15:0] divisor;

   assign divisor = {div_hi_r, div_lo_r};

   // Address and data are latched independently so the master may offer them in either order.
   assign o_awready = !aw_hold_r;
   assign o_wready = !w_hold_r;
   assign wr_fire = aw_hold_r && w_hold_r && !o_bvalid;

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_addr_r <= 10'h000;
         w_data_r <= 32'h0000_0000;
         w_lane_r <= 1'b0;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= i_awaddr;
         end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= i_wdata;
            w_lane_r <= i_wstrb[0];
         end else if (wr_fire) begin
            w_hold_r <= 1'b0;
         end
      end
   end

   // The byte address is four times the register index; writes to the status word or a hole answer with an error.
   logic w_ok;
   always_comb begin
      case (aw_addr_r[9:2])
         REG_IDX_DIV_HIGH, REG_IDX_DIV_LOW, REG_IDX_SYNC_IN, REG_IDX_SYNC_OUT: w_ok = 1'b1;
         REG_IDX_CLK_CFG, REG_IDX_CHAR_CFG: w_ok = 1'b1;
         default: w_ok = 1'b0;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         o_bvalid <= 1'b1;
         o_bresp <= w_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         div_hi_r <= RST_DIV;
         div_lo_r <= RST_DIV;
         sin_ctl_r <= RST_SYNC_IN;
         serial_data_output_ctl_r <= RST_SYNC_OUT;
         clk_cfg_r <= RST_CFG;
         chr_cfg_r <= RST_CFG;
         div_load_r <= 1'b0;
      end else begin
         div_load_r <= 1'b0;
         if (wr_fire && w_lane_r) begin
            case (aw_addr_r[9:2])
               REG_IDX_DIV_HIGH: begin
                  div_hi_r <= w_data_r[7:0];
                  div_load_r <= 1'b1;
               end
               REG_IDX_DIV_LOW: begin
                  div_lo_r <= w_data_r[7:0];
                  div_load_r <= 1'b1;
               end
               REG_IDX_SYNC_IN: sin_ctl_r <= w_data_r[7:0];
               REG_IDX_SYNC_OUT: serial_data_output_ctl_r <= w_data_r[7:0];
               REG_IDX_CLK_CFG: clk_cfg_r <= w_data_r[7:0];
               REG_IDX_CHAR_CFG: chr_cfg_r <= w_data_r[7:0];
               default: ;
            endcase
         end
      end
   end

   assign o_arready = !o_rvalid;

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_rvalid <= 1'b1;
         o_rresp <= RESP_OKAY;
         case (i_araddr[9:2])
            REG_IDX_DIV_HIGH: o_rdata <= {24'h000000, div_hi_r};
            REG_IDX_DIV_LOW: o_rdata <= {24'h000000, div_lo_r};
            REG_IDX_SYNC_IN: o_rdata <= {24'h000000, sin_ctl_r};
            REG_IDX_SYNC_OUT: o_rdata <= {24'h000000, serial_data_output_ctl_r};
            REG_IDX_CLK_CFG: o_rdata <= {24'h000000, clk_cfg_r};
            REG_IDX_CHAR_CFG: o_rdata <= {24'h000000, chr_cfg_r};
            REG_IDX_STATUS: o_rdata <= {28'h0000000, buf_cnt_r, req_r, phase_r};
            default: begin
               o_rdata <= 32'h0000_0000;
               o_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (i_rready) begin
         o_rvalid <= 1'b0;
      end
   end

   // Stick parity flips the even/odd choice for the transmit parity output.
   assign o_tx_parity_odd = ~(chr_cfg_r[BIT_EVEN_PAR] ^ clk_cfg_r[BIT_PAR_INV]);

   // Divider: a write reloads at once so no stale long count precedes the first period.
   always_comb begin
      cnt_nxt = cnt_r;
      if (divisor < DIV_MIN) begin
         cnt_nxt = '0;
      end else if (div_load_r || cnt_r <= DIV_W'(1)) begin
         cnt_nxt = DIV_W'(divisor);
      end else begin
         cnt_nxt = cnt_r - DIV_W'(1);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign tick = (divisor >= DIV_MIN) && !div_load_r && (cnt_r == DIV_W'(1));
   assign o_baud_tick = tick;

   assign sync_en = sin_ctl_r[BIT_SYNC_EN];
   assign echo = clk_cfg_r[BIT_ECHO];
   assign loop = clk_cfg_r[BIT_LOOP];
   assign sin_eff = sync_en ? sin_ctl_r : 8'h00;
   assign serial_data_output_eff = sync_en ? serial_data_output_ctl_r : 8'h00;

   // Disabled inputs read as their inactive level.
   assign in_data = sin_eff[BIT_INPUTS_OFF] ? 1'b1 : i_pins.data;
   assign in_clk = sin_eff[BIT_INPUTS_OFF] ? 1'b0 : i_pins.clk;
   assign in_carrier = sin_eff[BIT_INPUTS_OFF] ? ~sin_eff[BIT_CARRIER_LEVEL] : i_pins.carrier;
   assign carrier_active = (in_carrier == sin_eff[BIT_CARRIER_LEVEL]);

   // Receiver data: loopback takes the transmit bit, polarity ignored there.
   assign o_rx_data = loop ? cur_r.bit_data : (in_data ^ sin_eff[BIT_IN_INV]);

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         rx_clk_q_r <= 1'b0;
         rx_clk_prev_r <= 1'b0;
      end else begin
         rx_clk_q_r <= in_clk ^ sin_eff[BIT_RECEIVE_CLOCK_PIN_EDGE];
         rx_clk_prev_r <= rx_clk_q_r;
      end
   end

   // A gated clock edge only counts while the carrier is at its active level.
   assign o_rx_clk_tick = loop ? tick :
      (rx_clk_q_r && !rx_clk_prev_r && (!sin_eff[BIT_CARRIER_GATE] || carrier_active));

   // Two-entry buffer between the transmitter and the pin sequencer.
   logic buf_push, buf_pop;
   assign o_tx_ready = (buf_cnt_r != 2'd2);
   assign buf_push = i_tx_valid && o_tx_ready;
   assign buf_pop = (buf_cnt_r != 2'd0) && (!cur_valid_r || (tick && phase_r));

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         buf_cnt_r <= 2'd0;
         buf_rd_r <= 1'b0;
         buf_r[0] <= '0;
         buf_r[1] <= '0;
      end else begin
         if (buf_push) begin
            buf_r[buf_rd_r ^ buf_cnt_r[0]] <= i_tx_bit;
         end
         if (buf_pop) begin
            buf_rd_r <= ~buf_rd_r;
         end
         buf_cnt_r <= buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
      end
   end

   // Each bit spans two ticks: setup half then active-edge half.
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         cur_r <= '0;
         cur_valid_r <= 1'b0;
         phase_r <= 1'b0;
      end else begin
         if (buf_pop) begin
            cur_r <= buf_r[buf_rd_r];
            cur_valid_r <= 1'b1;
            phase_r <= 1'b0;
         end else if (cur_valid_r && tick) begin
            phase_r <= ~phase_r;
            if (phase_r) begin
               cur_valid_r <= 1'b0;
            end
         end
      end
   end

   // Request is raised with the first bit's setup and dropped after the last active edge.
   // A pop wins over the drop, so a frame queued right behind another stays framed.
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         req_r <= 1'b0;
      end else if (!serial_data_output_eff[BIT_REQ_FRAME]) begin
         req_r <= 1'b0;
      end else if (buf_pop) begin
         req_r <= 1'b1;
      end else if (cur_valid_r && tick && phase_r && cur_r.last) begin
         req_r <= 1'b0;
      end
   end

   logic clk_level, data_level, req_level;
   always_comb begin
      if (cur_valid_r) begin
         clk_level = phase_r ^ serial_data_output_eff[BIT_TXCLK_EDGE];
         data_level = cur_r.bit_data ^ serial_data_output_eff[BIT_OUT_INV];
      end else begin
         clk_level = ~serial_data_output_eff[BIT_TXCLK_IDLE];
         data_level = ~serial_data_output_eff[BIT_OUT_IDLE];
      end
      req_level = req_r ~^ serial_data_output_eff[BIT_REQ_LEVEL];
   end

   // Echo copies raw pins regardless of polarity bits; loopback holds data high.
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_pins <= '{data: 1'b1, clk: 1'b1, request: 1'b1};
      end else if (echo) begin
         o_pins <= '{data: i_pins.data, clk: i_pins.clk, request: i_pins.carrier};
      end else if (loop) begin
         o_pins <= '{data: 1'b1, clk: clk_level, request: 1'b1};
      end else begin
         o_pins <= '{data: data_level, clk: clk_level, request: req_level};
      end
   end

   a_div_halt: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (divisor < DIV_MIN) |-> !tick) else $error("Tick while divisor halts.");
   a_div_load: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      div_load_r && divisor >= DIV_MIN |=> cnt_r == divisor) else $error("Divisor not loaded.");
   sequence s_three_cycle_gap;
      !tick ##1 !tick ##1 tick;
   endsequence
   // A divisor write reloads the counter, so an attempt that sees a reload is dropped.
   a_div_period: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst || div_load_r)
      tick && divisor == 16'h0003 && !$changed(divisor) |=> s_three_cycle_gap)
      else $error("Wrong baud period.");
   a_sync_off: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      !sync_en && !echo && !loop && !cur_valid_r |=> o_pins.data && o_pins.clk) else $error("Sync off ignored.");
   a_echo_pins: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      echo |=> o_pins.clk == $past(i_pins.clk) && o_pins.request == $past(i_pins.carrier))
      else $error("Echo mismatch.");
   a_in_disable: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      sin_eff[BIT_INPUTS_OFF] && !loop |-> o_rx_data == ~sin_eff[BIT_IN_INV]) else $error("Input not cut.");
   a_gate_carrier: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      !loop && sin_eff[BIT_CARRIER_GATE] && !carrier_active |-> !o_rx_clk_tick) else $error("Gate leaked.");
   a_stick_parity: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      clk_cfg_r[BIT_PAR_INV] |-> o_tx_parity_odd == chr_cfg_r[BIT_EVEN_PAR]) else $error("Parity wrong.");
   a_req_frame: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      cur_valid_r && serial_data_output_eff[BIT_REQ_FRAME] && !$rose(cur_valid_r) |-> req_r) else $error("Request absent.");
endmodule

// [bench/remote_serial_dev.sv]
// Behavioural model of the remote serial device on the far side of the pins.
`timescale 1ns/1ps
module remote_serial_dev
   import sci_sync_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_clear,
   input wire logic i_clk_fall,
   input wire logic i_req_high,
   input wire logic i_carrier_high,
   input wire sci_sync_pkg::sync_out_pins_t i_pins,
   output sci_sync_pkg::sync_in_pins_t o_pins,
   output logic [7:0] o_bits,
   output logic [7:0] o_count
);
   logic prev_clk = 1'b1;
   logic in_frame = 1'b0;
   initial o_pins = '0;
   initial o_bits = 8'h00;
   initial o_count = 8'h00;
   // Bits are taken only on the active clock edge while the request is at its active level.
   always @(posedge i_sys_clk) begin
      prev_clk <= i_pins.clk;
      if (i_clear) begin
         o_count <= 8'h00;
      end else if (i_pins.request == i_req_high && i_pins.clk != prev_clk && i_pins.clk != i_clk_fall) begin
         o_bits[o_count[2:0]] <= i_pins.data;
         o_count <= o_count + 8'h01;
      end
   end
   // Between frames the clock stands still and the data line is not held, so it toggles.
   always @(posedge i_sys_clk) begin
      if (!in_frame) begin
         o_pins.data <= ~o_pins.data;
         o_pins.carrier <= ~i_carrier_high;
         o_pins.clk <= 1'b0;
      end
   end
   // The carrier is active for the whole frame and brackets every clock edge.
   task automatic send_frame(input int n, input logic d);
      @(negedge i_sys_clk);
      in_frame = 1'b1;
      @(posedge i_sys_clk);
      o_pins.carrier <= i_carrier_high;
      o_pins.data <= d;
      repeat (4) @(posedge i_sys_clk);
      repeat (2 * n) begin
         o_pins.clk <= ~o_pins.clk;
         repeat (4) @(posedge i_sys_clk);
      end
      in_frame = 1'b0;
   endtask
endmodule

// [bench/testbench.sv]
// Self-checking bench of the baud generator and sync pin control.
`timescale 1ns/1ps
module testbench;
   import sci_sync_pkg::*;
   logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic tx_valid = 0, clear = 0, clk_fall = 0, req_high = 1, car_high = 0;
   logic [9:0] awaddr = 0, araddr = 0;
   logic [7:0] cap, cap_cnt, v;
   logic [31:0] wdata = 0, rdata, d;
   logic [1:0] bresp, rresp, resp;
   logic awready, wready, bvalid, arready, rvalid, tx_ready, tick, rx_data, rx_tick, par_odd;
   logic [11:0] r;
   logic [11:0] rows [6] = '{12'h80F, 12'hC0E, 12'hA02, 12'h907, 12'h985, 12'h849};
   logic [15:0] divs [4] = '{16'h1001, 16'h0003, 16'h0002, 16'h0000};
   sync_in_pins_t pins_in;
   sync_out_pins_t pins_out;
   tx_bit_t tx_bit = '0;
   int failures = 0, compares = 0, seed = 41929, baud_cnt = 0, rx_ticks = 0, n, c0, stalls;

   always #2 clk = ~clk;
   always @(posedge clk) baud_cnt <= baud_cnt + (tick === 1'b1);
   always @(posedge clk) rx_ticks <= rx_ticks + (rx_tick === 1'b1);

   sci_sync_io DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_pins(pins_in), .o_pins(pins_out), .i_tx_bit(tx_bit), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
      .o_baud_tick(tick), .o_rx_data(rx_data), .o_rx_clk_tick(rx_tick), .o_tx_parity_odd(par_odd));

   remote_serial_dev u_remote (.i_sys_clk(clk), .i_clear(clear), .i_clk_fall(clk_fall), .i_req_high(req_high),
      .i_carrier_high(car_high), .i_pins(pins_out), .o_pins(pins_in), .o_bits(cap), .o_count(cap_cnt));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // The master judges ready and valid at the falling edge, where they equal what the next rising edge sees.
   task automatic wr(input logic [7:0] idx, input logic [7:0] dv);
      int k;
      logic a, w, b;
      @(posedge clk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, dv};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(negedge clk);
         a = awvalid & (awready === 1'b1);
         w = wvalid & (wready === 1'b1);
         b = (bvalid === 1'b1);
         resp = bresp;
         @(posedge clk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) begin
            bready <= 1'b0;
            break;
         end
      end
      if (k == 100) failures++;
   endtask

   task automatic rd(input logic [7:0] idx, output logic [31:0] dv);
      int k;
      logic a, b;
      @(posedge clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(negedge clk);
         a = arvalid & (arready === 1'b1);
         b = (rvalid === 1'b1);
         dv = rdata;
         resp = rresp;
         @(posedge clk);
         if (a) arvalid <= 1'b0;
         if (b) begin
            rready <= 1'b0;
            break;
         end
      end
      if (k == 100) failures++;
   endtask

   task automatic set_div(input logic [15:0] dv);
      wr(REG_IDX_DIV_HIGH, dv[15:8]);
      wr(REG_IDX_DIV_LOW, dv[7:0]);
   endtask

   task automatic wait_tick(output int c);
      for (c = 1; c < 9000; c++) begin
         @(negedge clk);
         if (tick === 1'b1) break;
      end
   endtask

   // Bits are offered faster than they leave, so the two-entry buffer must refuse some of them.
   task automatic tx_send(input logic [7:0] b);
      int i, k;
      logic t;
      @(posedge clk);
      i = 0;
      tx_valid <= 1'b1;
      tx_bit <= '{b[0], 1'b1, 1'b0};
      for (k = 0; k < 2000 && i < 8; k++) begin
         @(negedge clk);
         t = (tx_ready === 1'b1);
         @(posedge clk);
         if (!t) stalls++;
         if (t) begin
            i++;
            if (i < 8) tx_bit <= '{b[i], 1'b1, i == 7};
            else tx_valid <= 1'b0;
         end
      end
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(REG_IDX_SYNC_IN, d); check(d, {24'h0, RST_SYNC_IN});
      rd(REG_IDX_SYNC_OUT, d); check(d, {24'h0, RST_SYNC_OUT});
      rd(REG_IDX_DIV_LOW, d); check(d, 32'h0);
      rd(8'hF0, d); check(resp, RESP_SLVERR);
      wr(8'hF0, 8'h5A); check(resp, RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         wr(REG_IDX_SYNC_OUT, v);
         rd(REG_IDX_SYNC_OUT, d); check(d, {24'h0, v});
      end
      divs[3] = 16'h0002 + 16'($unsigned($random(seed)) % 40);
      for (int i = 0; i < 4; i++) begin
         set_div(divs[i]);
         wait_tick(n); check(n <= divs[i] + 16, 1);
         wait_tick(n); check(n, divs[i]);
      end
      for (int i = 0; i < 2; i++) begin
         set_div(16'(i));
         repeat (4) @(posedge clk);
         c0 = baud_cnt;
         repeat (64) @(posedge clk);
         check(baud_cnt - c0, 0);
      end
      for (int i = 0; i < 4; i++) begin
         wr(REG_IDX_CHAR_CFG, {1'b0, i[0], 6'h0});
         wr(REG_IDX_CLK_CFG, {7'h0, i[1]});
         @(negedge clk); check(par_odd, !(i[0] ^ i[1]));
      end
      wr(REG_IDX_SYNC_IN, 8'h80);
      wr(REG_IDX_SYNC_OUT, 8'h50);
      repeat (6) @(negedge clk);
      check(pins_out.data, 0);
      check(pins_out.clk, 0);
      wr(REG_IDX_SYNC_IN, 8'h00);
      repeat (6) @(negedge clk);
      check(pins_out.data, 1);
      set_div(16'h0004);
      for (int j = 0; j < 2; j++) begin
         clk_fall <= j[0];
         req_high <= ~j[0];
         wr(REG_IDX_SYNC_IN, 8'h80);
         wr(REG_IDX_SYNC_OUT, j ? 8'hA8 : 8'h0C);
         clear <= 1'b1;
         @(posedge clk);
         clear <= 1'b0;
         v = $random(seed);
         stalls = 0;
         tx_send(v);
         repeat (120) @(posedge clk);
         check(cap_cnt, 8);
         check(cap, v ^ {8{j[0]}});
         check(pins_out.request, j[0]);
         check(stalls > 0, 1);
      end
      // Loopback: the receiver takes the last sent bit, ticks at the baud rate, and the data pin stays high.
      wr(REG_IDX_CLK_CFG, 8'h02);
      wr(REG_IDX_SYNC_IN, 8'hC0);
      c0 = rx_ticks;
      repeat (64) @(posedge clk);
      check(rx_ticks - c0, 16);
      @(negedge clk);
      check(rx_data, v[7]);
      check(pins_out.data, 1);
      wr(REG_IDX_CLK_CFG, 8'h00);
      for (int i = 0; i < 6; i++) begin
         r = rows[i];
         car_high <= r[3];
         wr(REG_IDX_SYNC_IN, r[11:4]);
         // Flipping the edge select looks like an edge by itself, so the count starts a little later.
         repeat (3) @(posedge clk);
         c0 = rx_ticks;
         fork
            u_remote.send_frame(4, r[2]);
            begin
               repeat (12) @(posedge clk);
               @(negedge clk); check(rx_data, r[0]);
            end
         join
         repeat (8) @(posedge clk);
         check(rx_ticks - c0, r[1] ? 4 : 0);
      end
      car_high <= 1'b1;
      wr(REG_IDX_CLK_CFG, 8'h04);
      wr(REG_IDX_SYNC_IN, 8'hC0);
      wr(REG_IDX_SYNC_OUT, 8'h80);
      fork
         u_remote.send_frame(4, 1'b0);
         begin
            repeat (12) @(posedge clk);
            @(negedge clk); check(pins_out.data, 0);
            check(pins_out.request, 1);
         end
      join
      summarize();
   end

   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      summarize();
   end
endmodule
